//--- rsq_pkg.sv
// Package for the robot sequence command unit: register map, field
// layout of program commands, value ranges and timing counts.
// Assumes a single 100 MHz system clock shared by all users.
package rsq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  localparam int ADDR_W = 13;
  localparam logic [ADDR_W-1:0] REG_CTRL = 13'h0000;
  localparam logic [ADDR_W-1:0] REG_STATUS = 13'h0001;
  localparam logic [ADDR_W-1:0] REG_DOUT = 13'h0002;
  localparam logic [ADDR_W-1:0] REG_ROUT = 13'h0003;
  localparam logic [ADDR_W-1:0] REG_TOOL1_OFFSET_X = 13'h0259;
  localparam logic [ADDR_W-1:0] REG_TOOL1_OFFSET_Y = 13'h025A;
  localparam logic [ADDR_W-1:0] REG_TOOL1_OFFSET_Z = 13'h025B;
  localparam logic [ADDR_W-1:0] REG_TOOL2_OFFSET_X = 13'h10C6;
  localparam logic [ADDR_W-1:0] REG_TOOL2_OFFSET_Y = 13'h10C7;
  localparam logic [ADDR_W-1:0] REG_TOOL2_OFFSET_Z = 13'h10C8;
  localparam logic [ADDR_W-1:0] REG_STARTUP_OFFSET_SELECT = 13'h11CC;

  // Control register bits
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;

  // Reset values and limits
  localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;
  localparam logic [31:0] OFFSET_MAX = 32'h0001_86A0;
  localparam logic STARTUP_SEL_RESET = 1'h0;
  localparam logic [15:0] DOUT_RESET = 16'h0000;
  localparam logic [31:0] ROUT_RESET = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Program command word: [63:60] opcode, [59:48] control, [47:0] argument
  localparam int CMD_W = 64;
  localparam int PC_W = 10;
  typedef enum logic [3:0] {
    OP_END = 4'h0,
    OP_WAIT_TIME = 4'h1,
    OP_WAIT_SIG = 4'h2,
    OP_LOOP_START = 4'h3,
    OP_LOOP_END = 4'h4,
    OP_OUT_SINGLE = 4'h5,
    OP_OUT_MULTI = 4'h6,
    OP_TOOL = 4'h7,
    OP_COORD = 4'h8,
    OP_MOVE = 4'h9,
    OP_MOVE_DD = 4'hA
  } rsq_op_t;

  // Control field positions
  localparam int F_IDX_LSB = 48;
  localparam int F_REMOTE = 53;
  localparam int F_LEVEL = 54;
  localparam int F_MODE_LSB = 56;

  // Signal-output scope (single command) and group (masked command)
  localparam logic [1:0] SCOPE_ONE = 2'h0;
  localparam logic [1:0] SCOPE_ALL_DIRECT = 2'h1;
  localparam logic [1:0] SCOPE_ALL_REMOTE = 2'h2;
  localparam logic [1:0] SCOPE_ALL_BOTH = 2'h3;
  localparam logic [1:0] GROUP_REMOTE = 2'h0;
  localparam logic [1:0] GROUP_DIRECT = 2'h1;
  localparam logic [1:0] GROUP_BOTH = 2'h2;

  // Tool-offset choice, coordinate frames, fieldbus target sources
  localparam logic [1:0] TOOL_SET1 = 2'h0;
  localparam logic [1:0] TOOL_SET2 = 2'h1;
  localparam logic [1:0] TOOL_SWAP = 2'h2;
  localparam logic [1:0] FRAME_USER1 = 2'h0;
  localparam logic [1:0] SRC_CAM1 = 2'h0;
  localparam logic [1:0] SRC_CAM2 = 2'h1;
  localparam logic [1:0] SRC_POS = 2'h2;

  // Loop counts; zero in the count field means endless
  localparam logic [7:0] LOOP_MIN = 8'h02;
  localparam logic [7:0] LOOP_MAX = 8'hFE;
  localparam logic [7:0] LOOP_ENDLESS = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: waits count in 0.1 s units, 0.1 s to 65.5 s
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAIT_UNIT_NS = 100_000_000;
  localparam int WAIT_UNIT_CYCLES = WAIT_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [15:0] WAIT_MIN_UNITS = 16'h0001;
  localparam logic [15:0] WAIT_MAX_UNITS = 16'h028F;

endpackage : rsq_pkg

//--- rsq_program_store.sv
// Model of the program store and motion engine facing the sequencer.
// Assumes the bench supplies the program and picks prompt or slow answers.
`timescale 1ns/100ps
module rsq_program_store (
  input wire logic clk_sys_in,
  input wire logic slow_in,
  input wire logic [63:0] prog_in [16],
  input wire logic fetch_req_in,
  input wire logic [rsq_pkg::PC_W-1:0] fetch_addr_in,
  output logic cmd_valid_out,
  output logic [rsq_pkg::CMD_W-1:0] cmd_out,
  input wire logic move_start_in,
  output logic move_accept_out,
  output logic [7:0] moves_out
);
  logic wait_r = 1'b0;
  logic [1:0] mv_r = 2'h0;
  logic [63:0] last_r = 64'h0;
  // Slow mode answers on the second cycle; idle bus shows inverted data
  assign cmd_valid_out = fetch_req_in && (!slow_in || wait_r);
  assign cmd_out = cmd_valid_out ? prog_in[fetch_addr_in[3:0]] : ~last_r;
  assign move_accept_out = move_start_in && mv_r == 2'h2;
  // Wait, accept delay and move counting
  initial moves_out = 8'h00;
  always @(posedge clk_sys_in) begin
    wait_r <= fetch_req_in && !cmd_valid_out;
    mv_r <= move_start_in && !move_accept_out ? mv_r + 2'h1 : 2'h0;
    if (cmd_valid_out) last_r <= cmd_out;
    if (move_accept_out) moves_out <= moves_out + 8'h01;
  end
endmodule : rsq_program_store

//--- rsq_sequencer.sv
// Robot sequence command unit: fetches program commands and executes
// waits, loops, output updates, tool offset and frame changes, moves.
// Assumes a program store that raises cmd_valid_in when it answers a held fetch, a
// motion engine that accepts move starts, and asynchronous I/O lines.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps

module rsq_sequencer #(
  parameter int WAIT_UNIT_CYCLES = rsq_pkg::WAIT_UNIT_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [rsq_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Program store
  output logic fetch_req_out,
  output logic [rsq_pkg::PC_W-1:0] fetch_addr_out,
  input wire logic cmd_valid_in,
  input wire logic [rsq_pkg::CMD_W-1:0] cmd_in,
  // I/O lines
  input wire logic [15:0] direct_input_line_in,
  input wire logic [31:0] remote_input_line_in,
  output logic [15:0] direct_output_line_out,
  output logic [31:0] remote_output_line_out,
  // Cyclic fieldbus data
  input wire logic [31:0] dd_cam1_x_in,
  input wire logic [31:0] dd_cam1_y_in,
  input wire logic [31:0] dd_cam2_x_in,
  input wire logic [31:0] dd_cam2_y_in,
  input wire logic [31:0] dd_pos_x_in,
  input wire logic [31:0] dd_pos_y_in,
  input wire logic [31:0] dd_pos_z_in,
  // Motion engine
  output logic move_start_out,
  output logic move_dd_out,
  output logic move_z_valid_out,
  output logic [47:0] move_arg_out,
  output logic [31:0] move_target_x_out,
  output logic [31:0] move_target_y_out,
  output logic [31:0] move_target_z_out,
  input wire logic move_accept_in,
  output logic [31:0] tool_centre_point_x_out,
  output logic [31:0] tool_centre_point_y_out,
  output logic [31:0] tool_centre_point_z_out,
  output logic tool_set_out,
  output logic [1:0] frame_sel_out,
  output logic busy_out
);

  if (WAIT_UNIT_CYCLES < 1) begin : g_bad_unit
    $error("WAIT_UNIT_CYCLES must be at least one");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_EXEC, ST_WAIT_TIME, ST_WAIT_SIG, ST_MOVE
  } rsq_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Offset register index 0..5, or 7 when not an offset address
  function automatic logic [2:0] off_index(input logic [rsq_pkg::ADDR_W-1:0] a);
    unique case (a)
      rsq_pkg::REG_TOOL1_OFFSET_X: off_index = 3'h0;
      rsq_pkg::REG_TOOL1_OFFSET_Y: off_index = 3'h1;
      rsq_pkg::REG_TOOL1_OFFSET_Z: off_index = 3'h2;
      rsq_pkg::REG_TOOL2_OFFSET_X: off_index = 3'h3;
      rsq_pkg::REG_TOOL2_OFFSET_Y: off_index = 3'h4;
      rsq_pkg::REG_TOOL2_OFFSET_Z: off_index = 3'h5;
      default: off_index = 3'h7;
    endcase
  endfunction : off_index

  // Force masked bits to one level, keep the rest
  function automatic logic [31:0] force_bits(input logic [31:0] v, input logic [31:0] m,
                                             input logic lvl);
    force_bits = lvl ? (v | m) : (v & ~m);
  endfunction : force_bits

  ////////////////////////////////////////////////////////////////////////////
  // State

  rsq_state_t state_r;
  logic [rsq_pkg::PC_W-1:0] pc_r;
  logic [rsq_pkg::CMD_W-1:0] cmd_r;
  logic [31:0] tool_off_r [0:5];
  logic startup_sel_r;
  logic tool_set_r;
  logic [1:0] frame_r;
  logic [15:0] dout_r;
  logic [31:0] rout_r;
  logic [15:0] din_s1_r, din_s2_r;
  logic [31:0] rin_s1_r, rin_s2_r;
  logic [31:0] tick_cnt_r;
  logic [15:0] wait_cnt_r;
  logic [rsq_pkg::PC_W-1:0] loop_pc_r;
  logic [7:0] loop_left_r;
  logic loop_endless_r;
  logic loop_act_r;
  logic [31:0] rdata_r;
  logic move_start_r;
  logic move_dd_r;
  logic move_z_valid_r;
  logic [47:0] move_arg_r;
  logic [31:0] tgt_x_r, tgt_y_r, tgt_z_r;
  logic [31:0] tcp_x_r, tcp_y_r, tcp_z_r;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  wire rsq_pkg::rsq_op_t op = rsq_pkg::rsq_op_t'(cmd_r[63:60]);
  wire [4:0] sel_idx = cmd_r[rsq_pkg::F_IDX_LSB +: 5];
  wire sel_remote = cmd_r[rsq_pkg::F_REMOTE];
  wire sel_level = cmd_r[rsq_pkg::F_LEVEL];
  wire [1:0] sel_mode = cmd_r[rsq_pkg::F_MODE_LSB +: 2];
  wire src_pos = (sel_mode == rsq_pkg::SRC_POS);
  wire src_cam2 = (sel_mode == rsq_pkg::SRC_CAM2);
  wire [15:0] arg_units = cmd_r[15:0];
  wire [7:0] arg_loops = cmd_r[7:0];
  wire [rsq_pkg::PC_W-1:0] pc_inc = pc_r + 1'b1;

  // Selected input level for signal wait
  wire sig_now = sel_remote ? rin_s2_r[sel_idx] : din_s2_r[sel_idx[3:0]];
  wire sig_match = (sig_now == sel_level);

  // Wait length clamped to 0.1 s .. 65.5 s
  wire [15:0] wait_units = (arg_units < rsq_pkg::WAIT_MIN_UNITS) ? rsq_pkg::WAIT_MIN_UNITS :
                           (arg_units > rsq_pkg::WAIT_MAX_UNITS) ? rsq_pkg::WAIT_MAX_UNITS :
                           arg_units;
  wire tick = (tick_cnt_r == 32'(WAIT_UNIT_CYCLES - 1));

  // Loop count clamped to 2 .. 254, zero stays endless
  wire [7:0] loop_cnt = (arg_loops < rsq_pkg::LOOP_MIN) ? rsq_pkg::LOOP_MIN :
                        (arg_loops > rsq_pkg::LOOP_MAX) ? rsq_pkg::LOOP_MAX :
                        arg_loops;
  wire loop_again = loop_act_r && (loop_endless_r || loop_left_r > 8'h01);

  // Single output masks
  wire [31:0] one_hot = 32'h0000_0001 << sel_idx;
  wire [15:0] dmask_one = (sel_mode == rsq_pkg::SCOPE_ONE) ?
                          (sel_remote ? 16'h0000 : one_hot[15:0]) :
                          ((sel_mode == rsq_pkg::SCOPE_ALL_DIRECT ||
                            sel_mode == rsq_pkg::SCOPE_ALL_BOTH) ? 16'hFFFF : 16'h0000);
  wire [31:0] rmask_one = (sel_mode == rsq_pkg::SCOPE_ONE) ?
                          (sel_remote ? one_hot : 32'h0000_0000) :
                          ((sel_mode == rsq_pkg::SCOPE_ALL_REMOTE ||
                            sel_mode == rsq_pkg::SCOPE_ALL_BOTH) ? 32'hFFFF_FFFF : 32'h0000_0000);
  wire [31:0] dout_one = force_bits({16'h0000, dout_r}, {16'h0000, dmask_one}, sel_level);
  wire [31:0] rout_one = force_bits(rout_r, rmask_one, sel_level);

  // Masked output: remote pattern in [47:16], direct pattern in [15:0]
  wire multi_d = (sel_mode == rsq_pkg::GROUP_DIRECT) || (sel_mode == rsq_pkg::GROUP_BOTH);
  wire multi_r = (sel_mode == rsq_pkg::GROUP_REMOTE) || (sel_mode == rsq_pkg::GROUP_BOTH);
  wire [15:0] dout_multi = multi_d ? cmd_r[15:0] : dout_r;
  wire [31:0] rout_multi = multi_r ? cmd_r[47:16] : rout_r;

  // Tool set choice; swap takes the set not in use
  wire tool_nxt = (sel_mode == rsq_pkg::TOOL_SET2) ? 1'b1 :
                  (sel_mode == rsq_pkg::TOOL_SWAP) ? ~tool_set_r : 1'b0;

  // Register writes
  wire [2:0] wr_idx = off_index(reg_addr_in);
  wire [31:0] wr_clamped = (reg_wdata_in > rsq_pkg::OFFSET_MAX) ? rsq_pkg::OFFSET_MAX :
                           reg_wdata_in;
  wire ctrl_wr = reg_wr_in && (reg_addr_in == rsq_pkg::REG_CTRL);
  wire start_req = ctrl_wr && reg_wdata_in[rsq_pkg::CTRL_START_BIT];
  wire stop_req = ctrl_wr && reg_wdata_in[rsq_pkg::CTRL_STOP_BIT];

  // Read mux
  wire [2:0] rd_idx = off_index(reg_addr_in);
  wire [31:0] status_word = {17'h0_0000, pc_r, frame_r, tool_set_r,
                             loop_act_r, (state_r != ST_IDLE)};
  wire [31:0] rd_mux = (rd_idx != 3'h7) ? tool_off_r[rd_idx] :
                       (reg_addr_in == rsq_pkg::REG_STATUS) ? status_word :
                       (reg_addr_in == rsq_pkg::REG_DOUT) ? {16'h0000, dout_r} :
                       (reg_addr_in == rsq_pkg::REG_ROUT) ? rout_r :
                       (reg_addr_in == rsq_pkg::REG_STARTUP_OFFSET_SELECT) ?
                       {31'h0000_0000, startup_sel_r} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  always_ff @(posedge clk_sys_in) begin
    din_s1_r <= direct_input_line_in;
    din_s2_r <= din_s1_r;
    rin_s1_r <= remote_input_line_in;
    rin_s2_r <= rin_s1_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 6; i++) begin
        tool_off_r[i] <= rsq_pkg::OFFSET_RESET;
      end
      startup_sel_r <= rsq_pkg::STARTUP_SEL_RESET;
      rdata_r <= 32'h0;
    end else begin
      if (reg_wr_in && wr_idx != 3'h7) begin
        tool_off_r[wr_idx] <= wr_clamped;
      end
      if (reg_wr_in && reg_addr_in == rsq_pkg::REG_STARTUP_OFFSET_SELECT) begin
        startup_sel_r <= reg_wdata_in[0];
      end
      if (reg_rd_in) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Wait unit divider, restarted on each timed wait
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || state_r != ST_WAIT_TIME || tick) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      state_r <= ST_IDLE;
      pc_r <= '0;
      cmd_r <= '0;
      tool_set_r <= rsq_pkg::STARTUP_SEL_RESET;
      frame_r <= rsq_pkg::FRAME_USER1;
      dout_r <= rsq_pkg::DOUT_RESET;
      rout_r <= rsq_pkg::ROUT_RESET;
      wait_cnt_r <= 16'h0000;
      loop_pc_r <= '0;
      loop_left_r <= 8'h00;
      loop_endless_r <= 1'b0;
      loop_act_r <= 1'b0;
      move_start_r <= 1'b0;
      move_dd_r <= 1'b0;
      move_z_valid_r <= 1'b0;
      move_arg_r <= 48'h0;
      tgt_x_r <= 32'h0;
      tgt_y_r <= 32'h0;
      tgt_z_r <= 32'h0;
    end else if (stop_req) begin
      state_r <= ST_IDLE;
      move_start_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start_req) begin
            pc_r <= '0;
            loop_act_r <= 1'b0;
            tool_set_r <= startup_sel_r;
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (cmd_valid_in) begin
            cmd_r <= cmd_in;
            state_r <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          pc_r <= pc_inc;
          state_r <= ST_FETCH;
          case (op)
            rsq_pkg::OP_END: begin
              state_r <= ST_IDLE;
            end
            rsq_pkg::OP_WAIT_TIME: begin
              wait_cnt_r <= wait_units;
              state_r <= ST_WAIT_TIME;
            end
            rsq_pkg::OP_WAIT_SIG: begin
              state_r <= ST_WAIT_SIG;
            end
            rsq_pkg::OP_LOOP_START: begin
              loop_pc_r <= pc_inc;
              loop_act_r <= 1'b1;
              loop_endless_r <= (arg_loops == rsq_pkg::LOOP_ENDLESS);
              loop_left_r <= loop_cnt;
            end
            rsq_pkg::OP_LOOP_END: begin
              if (loop_again) begin
                pc_r <= loop_pc_r;
                loop_left_r <= loop_left_r - 8'h01;
              end else begin
                loop_act_r <= 1'b0;
              end
            end
            rsq_pkg::OP_OUT_SINGLE: begin
              dout_r <= dout_one[15:0];
              rout_r <= rout_one;
            end
            rsq_pkg::OP_OUT_MULTI: begin
              dout_r <= dout_multi;
              rout_r <= rout_multi;
            end
            rsq_pkg::OP_TOOL: begin
              tool_set_r <= tool_nxt;
            end
            rsq_pkg::OP_COORD: begin
              frame_r <= sel_mode;
            end
            rsq_pkg::OP_MOVE: begin
              move_dd_r <= 1'b0;
              move_arg_r <= cmd_r[47:0];
              move_start_r <= 1'b1;
              state_r <= ST_MOVE;
            end
            rsq_pkg::OP_MOVE_DD: begin
              move_dd_r <= 1'b1;
              move_arg_r <= cmd_r[47:0];
              move_z_valid_r <= src_pos;
              tgt_x_r <= src_pos ? dd_pos_x_in : src_cam2 ? dd_cam2_x_in : dd_cam1_x_in;
              tgt_y_r <= src_pos ? dd_pos_y_in : src_cam2 ? dd_cam2_y_in : dd_cam1_y_in;
              tgt_z_r <= src_pos ? dd_pos_z_in : 32'h0;
              move_start_r <= 1'b1;
              state_r <= ST_MOVE;
            end
            default: begin
            end
          endcase
        end
        ST_WAIT_TIME: begin
          if (tick) begin
            wait_cnt_r <= wait_cnt_r - 16'h0001;
            if (wait_cnt_r == 16'h0001) begin
              state_r <= ST_FETCH;
            end
          end
        end
        ST_WAIT_SIG: begin
          if (sig_match) begin
            state_r <= ST_FETCH;
          end
        end
        ST_MOVE: begin
          // Only acceptance is awaited, not the end of motion
          if (move_accept_in) begin
            move_start_r <= 1'b0;
            state_r <= ST_FETCH;
          end
        end
      endcase
    end
  end

  // Active tool centre point follows the selected set
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      tcp_x_r <= rsq_pkg::OFFSET_RESET;
      tcp_y_r <= rsq_pkg::OFFSET_RESET;
      tcp_z_r <= rsq_pkg::OFFSET_RESET;
    end else begin
      tcp_x_r <= tool_set_r ? tool_off_r[3] : tool_off_r[0];
      tcp_y_r <= tool_set_r ? tool_off_r[4] : tool_off_r[1];
      tcp_z_r <= tool_set_r ? tool_off_r[5] : tool_off_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_out = rdata_r;
  assign fetch_req_out = (state_r == ST_FETCH);
  assign fetch_addr_out = pc_r;
  assign direct_output_line_out = dout_r;
  assign remote_output_line_out = rout_r;
  assign move_start_out = move_start_r;
  assign move_dd_out = move_dd_r;
  assign move_z_valid_out = move_z_valid_r;
  assign move_arg_out = move_arg_r;
  assign move_target_x_out = tgt_x_r;
  assign move_target_y_out = tgt_y_r;
  assign move_target_z_out = tgt_z_r;
  assign tool_centre_point_x_out = tcp_x_r;
  assign tool_centre_point_y_out = tcp_y_r;
  assign tool_centre_point_z_out = tcp_z_r;
  assign tool_set_out = tool_set_r;
  assign frame_sel_out = frame_r;
  assign busy_out = (state_r != ST_IDLE);

endmodule : rsq_sequencer

//--- rsq_sequencer_assertions.sv
// Checker for the sequencer: register port, fetch and move handshakes.
// Assumes one clock domain and an active-low synchronous reset.
`timescale 1ns/100ps
module rsq_sequencer_assertions (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [rsq_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic fetch_req_out,
  input wire logic [rsq_pkg::PC_W-1:0] fetch_addr_out,
  input wire logic cmd_valid_in,
  input wire logic [15:0] direct_output_line_out,
  input wire logic [31:0] remote_output_line_out,
  input wire logic move_start_out,
  input wire logic move_dd_out,
  input wire logic move_z_valid_out,
  input wire logic [31:0] move_target_x_out,
  input wire logic [31:0] move_target_z_out,
  input wire logic move_accept_in,
  input wire logic tool_set_out,
  input wire logic [1:0] frame_sel_out,
  input wire logic busy_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////////////////
  // Handshake steps and an oversized offset write
  sequence s_taken; fetch_req_out && cmd_valid_in; endsequence
  sequence s_pend; move_start_out && !move_accept_in; endsequence
  sequence s_big_wr;
    reg_wr_in && reg_addr_in == rsq_pkg::REG_TOOL1_OFFSET_X && reg_wdata_in > rsq_pkg::OFFSET_MAX;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_reset_clear: assert property (disable iff (1'b0) !rst_b_in ##1 rst_b_in |->
    !busy_out && direct_output_line_out == 16'h0000 && !tool_set_out && frame_sel_out == 2'h0)
    else $error("outputs not cleared by reset");
  a_offset_clamp: assert property (s_big_wr ##1 reg_rd_in &&
    reg_addr_in == rsq_pkg::REG_TOOL1_OFFSET_X |=> reg_rdata_out == rsq_pkg::OFFSET_MAX)
    else $error("offset not limited");
  a_fetch_hold: assert property (fetch_req_out && !cmd_valid_in && !reg_wr_in |=>
    fetch_req_out && $stable(fetch_addr_out)) else $error("fetch request dropped");
  a_exec_gap: assert property (s_taken |=> !fetch_req_out)
    else $error("fetch without execute cycle");
  a_move_hold: assert property (s_pend |=> move_start_out && $stable(move_target_x_out))
    else $error("move start not held");
  a_move_drop: assert property (move_start_out && move_accept_in |=> !move_start_out)
    else $error("move start stuck after accept");
  a_cam_no_z: assert property (move_start_out && move_dd_out && !move_z_valid_out |->
    move_target_z_out == 32'h0000_0000) else $error("camera move carries Z");
  a_idle_still: assert property (!busy_out && !reg_wr_in |=>
    $stable(remote_output_line_out) && $stable(tool_set_out)) else $error("idle output change");
  a_idle_quiet: assert property (!busy_out |-> !fetch_req_out && !move_start_out)
    else $error("idle unit fetching or moving");
endmodule : rsq_sequencer_assertions

bind rsq_sequencer rsq_sequencer_assertions u_chk (
  .clk_sys_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .fetch_req_out, .fetch_addr_out, .cmd_valid_in,
  .direct_output_line_out, .remote_output_line_out, .move_start_out,
  .move_dd_out, .move_z_valid_out, .move_target_x_out, .move_target_z_out,
  .move_accept_in, .tool_set_out, .frame_sel_out, .busy_out);

//--- tb_robot_sequence_command_unit.sv
// Testbench for the robot sequence command unit.
// Assumes rsq_pkg, the sequencer, its checker and the store model.
`timescale 1ns/100ps
module tb_robot_sequence_command_unit;
  typedef struct {logic [12:0] a; logic [31:0] d; logic [31:0] e;} rsq_row_t;
  logic clk_sys_in = 1'b0, rst_b_in = 1'b0, wr = 1'b0, rd = 1'b0, slow = 1'b0;
  logic [12:0] addr = 13'h0000;
  logic [31:0] wdata = 32'h0, rdata, rout, tx, tz, tcp_x;
  logic [31:0] pos_x = 32'h0000_0123, pos_y = 32'h0000_0456, pos_z = 32'h0000_0789;
  logic [15:0] din = 16'hFFF7, dout;
  logic [31:0] rin = 32'h0000_0000;
  logic [63:0] prog [16];
  logic [9:0] faddr;
  logic [63:0] cmd;
  logic freq, cval, mstart, macc, zval, tset, busy;
  logic [1:0] frame;
  logic [7:0] moves;
  int n_mismatch = 0, num_checks = 0, k;
  rsq_row_t rows [7] = '{
    '{rsq_pkg::REG_TOOL1_OFFSET_X, 32'h0001_86A1, 32'h0001_86A0},
    '{rsq_pkg::REG_TOOL1_OFFSET_Y, 32'h0000_1234, 32'h0000_1234},
    '{rsq_pkg::REG_TOOL1_OFFSET_Z, 32'h0001_86A0, 32'h0001_86A0},
    '{rsq_pkg::REG_TOOL2_OFFSET_X, 32'h0000_0042, 32'h0000_0042},
    '{rsq_pkg::REG_TOOL2_OFFSET_Y, 32'hFFFF_FFFF, 32'h0001_86A0},
    '{13'h0004, 32'hFFFF_FFFF, 32'h0000_0000},
    '{rsq_pkg::REG_STARTUP_OFFSET_SELECT, 32'h0000_0001, 32'h0000_0001}};
  always #5 clk_sys_in = ~clk_sys_in;
  ////////////////////////////////////////////////////////////////////////////
  rsq_sequencer #(.WAIT_UNIT_CYCLES(10)) u_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .fetch_req_out(freq), .fetch_addr_out(faddr), .cmd_valid_in(cval),
    .cmd_in(cmd), .direct_input_line_in(din), .remote_input_line_in(rin),
    .direct_output_line_out(dout), .remote_output_line_out(rout),
    .dd_cam1_x_in(32'h11), .dd_cam1_y_in(32'h12), .dd_cam2_x_in(32'h21), .dd_cam2_y_in(32'h22),
    .dd_pos_x_in(pos_x), .dd_pos_y_in(pos_y), .dd_pos_z_in(pos_z), .move_start_out(mstart),
    .move_dd_out(), .move_z_valid_out(zval), .move_arg_out(), .move_target_x_out(tx),
    .move_target_y_out(), .move_target_z_out(tz), .move_accept_in(macc),
    .tool_centre_point_x_out(tcp_x), .tool_centre_point_y_out(), .tool_centre_point_z_out(),
    .tool_set_out(tset), .frame_sel_out(frame), .busy_out(busy));
  rsq_program_store u_store (.clk_sys_in, .slow_in(slow), .prog_in(prog),
    .fetch_req_in(freq), .fetch_addr_in(faddr), .cmd_valid_out(cval), .cmd_out(cmd),
    .move_start_in(mstart), .move_accept_out(macc), .moves_out(moves));
  ////////////////////////////////////////////////////////////////////////////
  // Comparison, bus cycles and verdict
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [12:0] a, input logic [31:0] d);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [12:0] a, output logic [31:0] d);
    rd <= 1'b1; addr <= a;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    @(posedge clk_sys_in);
    d = rdata;
  endtask : rd_reg
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  function automatic logic [63:0] mk(input logic [3:0] op, input logic [11:0] c,
                                     input logic [47:0] g);
    return {op, c, g};
  endfunction : mk
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  // Main sequence
  initial begin
    logic [31:0] v;
    prog = '{mk(4'h5, 12'h140, 48'h0), mk(4'h2, 12'h043, 48'h0),
      mk(4'h6, 12'h000, 48'hA5A5_0F0F_0000), mk(4'h3, 12'h000, 48'h3),
      mk(4'h9, 12'h000, 48'h1), mk(4'h4, 12'h000, 48'h0), mk(4'h7, 12'h200, 48'h0),
      mk(4'h8, 12'h300, 48'h0), mk(4'hA, 12'h200, 48'h0), mk(4'h5, 12'h200, 48'h0),
      mk(4'h1, 12'h000, 48'h2), mk(4'h5, 12'h100, 48'h0),
      mk(4'h0, 12'h0, 48'h0), mk(4'h0, 12'h0, 48'h0), mk(4'h0, 12'h0, 48'h0), 64'h0};
    repeat (4) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(posedge clk_sys_in);
    foreach (rows[i]) begin
      rd_reg(rows[i].a, v);
      check("reset value", v, 32'h0);
    end
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, v);
      check("register", v, rows[i].e);
    end
    $display("test registers done");
    slow <= 1'b1;
    wr_reg(rsq_pkg::REG_CTRL, 32'h1);
    for (k = 0; k < 50 && dout !== 16'hFFFF; k++) @(posedge clk_sys_in);
    check("all direct on", {16'h0, dout}, 32'h0000_FFFF);
    repeat (30) @(posedge clk_sys_in);
    check("held by signal wait", rout, 32'h0);
    check("startup set", {31'h0, tset}, 32'h1);
    check("tcp set two", tcp_x, 32'h0000_0042);
    din <= 16'h0008;
    for (k = 0; k < 20 && rout !== 32'hA5A5_0F0F; k++) @(posedge clk_sys_in);
    check("wait release", {31'h0, k < 10}, 32'h1);
    check("masked remote", rout, 32'hA5A5_0F0F);
    for (k = 0; k < 300 && rout !== 32'h0; k++) @(posedge clk_sys_in);
    check("loop moves", {24'h0, moves}, 32'h4);
    check("direct kept", {16'h0, dout}, 32'h0000_FFFF);
    for (k = 0; k < 100 && dout !== 16'h0; k++) @(posedge clk_sys_in);
    check("timed wait", {31'h0, k >= 20}, 32'h1);
    for (k = 0; k < 50 && busy !== 1'b0; k++) @(posedge clk_sys_in);
    check("swap", {31'h0, tset}, 32'h0);
    check("tcp set one", tcp_x, 32'h0001_86A0);
    check("frame", {30'h0, frame}, 32'h3);
    check("dd x", tx, pos_x);
    check("dd z", tz, pos_z);
    check("dd z valid", {31'h0, zval}, 32'h1);
    $display("test program done");
    wr_reg(rsq_pkg::REG_CTRL, 32'h1);
    repeat (6) @(posedge clk_sys_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(posedge clk_sys_in);
    check("busy after reset", {31'h0, busy}, 32'h0);
    check("outputs after reset", {16'h0, dout}, 32'h0);
    $display("test reset done");
    print_verdict();
  end
endmodule : tb_robot_sequence_command_unit
